// [cpt_auto_model.sv]
module cpt_auto_model (
    input  wire logic            mclk,    // Register clock
    input  wire logic            reset_n, // Async reset
    input  wire logic            step,    // Load fresh computed values
    output logic      [9:0][6:0] auto_v   // Computed timing per slot
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0][6:0] cur = {10{7'h2a}};
    // Stands in for the automatic timing calculation
    always @(posedge mclk or negedge reset_n) begin
        for (int i = 0; i < 10; i++) begin
            if (!reset_n) begin
                cur[i] <= 7'(i * 9 + 5);
            end else if (step) begin
                cur[i] <= 7'($urandom);
            end
        end
    end
    assign auto_v = cur;
endmodule : cpt_auto_model

// [cpt_pkg.sv]
package cpt_pkg;

    // Register word indices; byte address is four times the index
    localparam logic [6:0] P0_LP_PERIOD_IDX    = 7'h48;
    localparam logic [6:0] P1_CLK_PREPARE_IDX  = 7'h60;
    localparam logic [6:0] P1_CLK_ZERO_IDX     = 7'h61;
    localparam logic [6:0] P1_CLK_TRAIL_IDX    = 7'h62;
    localparam logic [6:0] P1_CLK_POST_IDX     = 7'h63;
    localparam logic [6:0] P1_DATA_PREPARE_IDX = 7'h64;
    localparam logic [6:0] P1_DATA_ZERO_IDX    = 7'h65;
    localparam logic [6:0] P1_DATA_TRAIL_IDX   = 7'h66;
    localparam logic [6:0] P1_DATA_EXIT_IDX    = 7'h67;
    localparam logic [6:0] P1_LP_PERIOD_IDX    = 7'h68;

    localparam int NUM_REGS = 10;

    // Slot order inside the block, listed from slot 9 down to slot 0
    localparam logic [NUM_REGS-1:0][6:0] REG_IDX = {
        P1_LP_PERIOD_IDX,
        P1_DATA_EXIT_IDX,
        P1_DATA_TRAIL_IDX,
        P1_DATA_ZERO_IDX,
        P1_DATA_PREPARE_IDX,
        P1_CLK_POST_IDX,
        P1_CLK_TRAIL_IDX,
        P1_CLK_ZERO_IDX,
        P1_CLK_PREPARE_IDX,
        P0_LP_PERIOD_IDX
    };

    // Field layout of every timing register
    localparam int OVERRIDE_BIT = 7;
    localparam int VALUE_MSB    = 6;
    localparam int VALUE_W      = 7;
    localparam int ADR_W        = 9;

    // Reset values
    localparam logic               OVERRIDE_RST = 1'b0;
    localparam logic [VALUE_W-1:0] VALUE_RST    = 7'h00;
    localparam logic [31:0]        RDATA_RST    = 32'h0000_0000;

    typedef struct packed {
        logic [NUM_REGS-1:0]              ov;
        logic [NUM_REGS-1:0][VALUE_W-1:0] val;
        logic                             ack;
        logic [31:0]                      rdata;
    } cpt_state_s;

endpackage : cpt_pkg

// [cpt_timing_override_regs.sv]
// Notes on behaviour
// [RL1] Bit 7 of each timing register picks the source: 0 uses the automatic value, 1 uses bits 6:0.
// [RL2] With override clear the value field ignores writes and reads back the live automatic value.
// [RL3] With override set the value field takes writes, reads them back and drives the port timing.
// [RL4] Override bits and value fields reset to zero, so automatic timing rules after reset.
// [RL5] Each clock-lane, data-lane and low-power parameter has its own override control.
// [RL6] Port 1 holds nine contiguous timing registers, data exit directly before low-power period.
// [RL7] Port 0 low-power period register steers only port 0, apart from port 1's copy.
// [RL8] All timing values count byte-clock cycles of the output port.
//
// Local design decision: register access over Wishbone.
module cpt_timing_override_regs (
    input  wire logic                              mclk,                       // Register clock
    input  wire logic                              reset_n,                    // Async reset
    input  wire logic                              wb_cyc_i,                   // Bus cycle
    input  wire logic                              wb_stb_i,                   // Strobe
    input  wire logic                              wb_we_i,                    // Write enable
    input  wire logic [cpt_pkg::ADR_W-1:0]         wb_adr_i,                   // Byte address
    input  wire logic [3:0]                        wb_sel_i,                   // Byte lanes
    input  wire logic [31:0]                       wb_dat_i,                   // Write data
    output logic      [31:0]                       wb_dat_o,                   // Read data
    output logic                                   wb_ack_o,                   // Acknowledge
    input  wire logic [cpt_pkg::VALUE_W-1:0]       p0_auto_lp_period,          // Computed value
    input  wire logic [cpt_pkg::VALUE_W-1:0]       p1_auto_clk_prepare,        // Computed value
    input  wire logic [cpt_pkg::VALUE_W-1:0]       p1_auto_clk_zero,           // Computed value
    input  wire logic [cpt_pkg::VALUE_W-1:0]       p1_auto_clk_trail,          // Computed value
    input  wire logic [cpt_pkg::VALUE_W-1:0]       p1_auto_clk_post,           // Computed value
    input  wire logic [cpt_pkg::VALUE_W-1:0]       p1_auto_data_prepare,       // Computed value
    input  wire logic [cpt_pkg::VALUE_W-1:0]       p1_auto_data_zero,          // Computed value
    input  wire logic [cpt_pkg::VALUE_W-1:0]       p1_auto_data_trail,         // Computed value
    input  wire logic [cpt_pkg::VALUE_W-1:0]       p1_auto_data_exit,          // Computed value
    input  wire logic [cpt_pkg::VALUE_W-1:0]       p1_auto_lp_period,          // Computed value
    output logic      [cpt_pkg::VALUE_W-1:0]       p0_lp_period_value,         // Timing in use
    output logic      [cpt_pkg::VALUE_W-1:0]       p1_clk_prepare_value,       // Timing in use
    output logic      [cpt_pkg::VALUE_W-1:0]       p1_clk_zero_value,          // Timing in use
    output logic      [cpt_pkg::VALUE_W-1:0]       p1_clk_trail_value,         // Timing in use
    output logic      [cpt_pkg::VALUE_W-1:0]       p1_clk_post_value,          // Timing in use
    output logic      [cpt_pkg::VALUE_W-1:0]       p1_data_prepare_value,      // Timing in use
    output logic      [cpt_pkg::VALUE_W-1:0]       p1_data_zero_value,         // Timing in use
    output logic      [cpt_pkg::VALUE_W-1:0]       p1_data_trail_value,        // Timing in use
    output logic      [cpt_pkg::VALUE_W-1:0]       p1_data_exit_value,         // Timing in use
    output logic      [cpt_pkg::VALUE_W-1:0]       p1_lp_period_value,         // Timing in use
    output logic      [cpt_pkg::NUM_REGS-1:0]      override_en                 // Override bits
);

    cpt_pkg::cpt_state_s                                 st_reg;
    cpt_pkg::cpt_state_s                                 st_next;
    logic [cpt_pkg::NUM_REGS-1:0][cpt_pkg::VALUE_W-1:0]  auto_vec;
    logic [cpt_pkg::NUM_REGS-1:0][cpt_pkg::VALUE_W-1:0]  eff_vec;
    logic [cpt_pkg::NUM_REGS-1:0]                        hit;
    logic [cpt_pkg::NUM_REGS-1:0]                        wr_hit;
    logic [6:0]                                          word_idx;
    logic                                                req;
    logic                                                rd_req;
    logic [31:0]                                         rd_word;

    // Gather computed values into slot order
    assign auto_vec[0] = p0_auto_lp_period;
    assign auto_vec[1] = p1_auto_clk_prepare;
    assign auto_vec[2] = p1_auto_clk_zero;
    assign auto_vec[3] = p1_auto_clk_trail;
    assign auto_vec[4] = p1_auto_clk_post;
    assign auto_vec[5] = p1_auto_data_prepare;
    assign auto_vec[6] = p1_auto_data_zero;
    assign auto_vec[7] = p1_auto_data_trail;
    assign auto_vec[8] = p1_auto_data_exit;
    assign auto_vec[9] = p1_auto_lp_period;

    // Source select per parameter, one slot each
    always_comb begin
        for (int i = 0; i < cpt_pkg::NUM_REGS; i++) begin
            eff_vec[i] = st_reg.ov[i] ? st_reg.val[i] : auto_vec[i];    // [RL1] [RL3] [RL5]
        end
    end

    // Values below count byte-clock cycles of the lane sequencer
    assign p0_lp_period_value    = eff_vec[0];                        // [RL7] [RL8]
    assign p1_clk_prepare_value  = eff_vec[1];                        // [RL8]
    assign p1_clk_zero_value     = eff_vec[2];
    assign p1_clk_trail_value    = eff_vec[3];
    assign p1_clk_post_value     = eff_vec[4];
    assign p1_data_prepare_value = eff_vec[5];
    assign p1_data_zero_value    = eff_vec[6];
    assign p1_data_trail_value   = eff_vec[7];
    assign p1_data_exit_value    = eff_vec[8];
    assign p1_lp_period_value    = eff_vec[9];
    assign override_en           = st_reg.ov;

    assign wb_ack_o = st_reg.ack;
    assign wb_dat_o = st_reg.rdata;

    // Bus decode; byte offset bits are ignored
    assign word_idx = wb_adr_i[cpt_pkg::ADR_W-1:2];
    assign req      = wb_cyc_i && wb_stb_i;
    assign rd_req   = req && !wb_we_i && !st_reg.ack;

    always_comb begin
        for (int i = 0; i < cpt_pkg::NUM_REGS; i++) begin
            hit[i]    = (word_idx == cpt_pkg::REG_IDX[i]);            // [RL6] [RL7]
            wr_hit[i] = hit[i] && req && wb_we_i && st_reg.ack && wb_sel_i[0];
        end
    end

    // Read mux; unmapped words read zero
    always_comb begin
        rd_word = 32'h0000_0000;
        for (int i = 0; i < cpt_pkg::NUM_REGS; i++) begin
            if (hit[i]) begin
                rd_word[cpt_pkg::OVERRIDE_BIT]  = st_reg.ov[i];
                rd_word[cpt_pkg::VALUE_MSB:0]   = eff_vec[i];       // [RL2] [RL3]
            end
        end
    end

    always_comb begin
        st_next     = st_reg;
        st_next.ack = req && !st_reg.ack;
        if (rd_req) begin
            st_next.rdata = rd_word;
        end
        for (int i = 0; i < cpt_pkg::NUM_REGS; i++) begin
            if (wr_hit[i]) begin
                st_next.ov[i] = wb_dat_i[cpt_pkg::OVERRIDE_BIT];    // [RL1]
                // Value field only writable when override ends up set
                if (wb_dat_i[cpt_pkg::OVERRIDE_BIT]) begin
                    st_next.val[i] = wb_dat_i[cpt_pkg::VALUE_MSB:0]; // [RL2] [RL3]
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg.ov    <= {cpt_pkg::NUM_REGS{cpt_pkg::OVERRIDE_RST}};  // [RL4]
            st_reg.val   <= {cpt_pkg::NUM_REGS{cpt_pkg::VALUE_RST}};     // [RL4]
            st_reg.ack   <= 1'b0;
            st_reg.rdata <= cpt_pkg::RDATA_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    chk_reset_clears_all: assert property (disable iff (1'b0) // [RL4]
        !reset_n |=> st_reg.ov == '0 && st_reg.val == '0)
        else $error("timing registers not cleared by reset");

    chk_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    chk_ack_latency: assert property (req && !wb_ack_o |=> wb_ack_o)
        else $error("ack not given one cycle after request");

    chk_unmapped_zero: assert property (rd_req && hit == '0 |=> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read did not return zero");

    // Bus handshake and register-state checks
    chk_ack_needs_req: assert property (
        wb_ack_o
        |-> $past(req))
        else $error("ack without a request");

    chk_ack_drops_idle: assert property (
        !req
        |=> !wb_ack_o)
        else $error("ack raised with no request");

    chk_read_gets_word: assert property ( // [RL2]
        rd_req
        |=> wb_dat_o == $past(rd_word))
        else $error("read data not loaded from addressed word");

    chk_rdata_hold: assert property (
        !rd_req
        |=> $stable(wb_dat_o))
        else $error("read data changed without a read");

    chk_rdata_upper: assert property (wb_dat_o[31:8] == 24'h00_0000)
        else $error("unused read bits not zero");

    chk_write_needs_ack: assert property (wr_hit != '0 |-> wb_ack_o && wb_we_i && wb_sel_i[0])
        else $error("register written outside the acknowledged edge");

    chk_sel_ignored: assert property (
        req && wb_we_i && wb_ack_o && !wb_sel_i[0]
        |=> $stable(st_reg.ov) && $stable(st_reg.val))
        else $error("write without low byte lane changed a register");

    chk_idle_keeps_regs: assert property ( // [RL2]
        wr_hit == '0
        |=> $stable(st_reg.ov) && $stable(st_reg.val))
        else $error("register changed without a write");

    chk_read_no_write: assert property ( // [RL2]
        req && !wb_we_i
        |=> $stable(st_reg.ov) && $stable(st_reg.val))
        else $error("read changed a register");

    chk_unmapped_write: assert property ( // [RL6]
        req && wb_we_i && wb_ack_o && hit == '0
        |=> $stable(st_reg.ov) && $stable(st_reg.val))
        else $error("unmapped write changed a register");

    chk_single_hit: assert property ($onehot0(hit)) // [RL6]
        else $error("address decodes to more than one register");

    chk_reset_idle_bus: assert property (disable iff (1'b0) // [RL4]
        !reset_n
        |=> !wb_ack_o && wb_dat_o == 32'h0000_0000)
        else $error("bus outputs not cleared by reset");

    genvar g;
    for (g = 0; g < cpt_pkg::NUM_REGS; g++) begin : g_chk

        chk_auto_source: assert property (!st_reg.ov[g] |-> eff_vec[g] == auto_vec[g]) // [RL1]
            else $error("automatic value not in use while override clear");

        chk_clear_keeps_auto: assert property ( // [RL2]
            wr_hit[g] && !wb_dat_i[cpt_pkg::OVERRIDE_BIT]
            |=> !st_reg.ov[g] && $stable(st_reg.val[g]))
            else $error("value field changed by write with override clear");

        chk_override_write: assert property ( // [RL3]
            wr_hit[g] && wb_dat_i[cpt_pkg::OVERRIDE_BIT]
            |=> st_reg.ov[g] && eff_vec[g] == $past(wb_dat_i[cpt_pkg::VALUE_MSB:0]))
            else $error("override write not applied to port timing");

        chk_readback_word: assert property ( // [RL2]
            rd_req && hit[g]
            |=> wb_dat_o == {24'h0000_00, $past(st_reg.ov[g]), $past(eff_vec[g])})
            else $error("read data does not match register state");

        chk_no_cross_write: assert property ( // [RL5]
            wr_hit != '0 && !wr_hit[g] |=> $stable(st_reg.ov[g]) && $stable(st_reg.val[g]))
            else $error("write disturbed another timing register");

        // Source select and readback per slot
        chk_override_drive: assert property (st_reg.ov[g] |-> eff_vec[g] == st_reg.val[g]) // [RL3]
            else $error("stored value not driving port timing");

        chk_override_stable: assert property ( // [RL3]
            st_reg.ov[g] && !wr_hit[g]
            |=> $stable(eff_vec[g]))
            else $error("overridden timing moved without a write");

        chk_ov_set_holds: assert property ( // [RL3]
            st_reg.ov[g] && !wr_hit[g]
            |=> st_reg.ov[g] && $stable(st_reg.val[g]))
            else $error("override dropped without a write");

        chk_ov_bit_written: assert property ( // [RL1]
            wr_hit[g]
            |=> st_reg.ov[g] == $past(wb_dat_i[cpt_pkg::OVERRIDE_BIT]))
            else $error("override bit does not follow written bit");

        chk_clear_uses_auto: assert property ( // [RL1]
            wr_hit[g] && !wb_dat_i[cpt_pkg::OVERRIDE_BIT]
            |=> eff_vec[g] == auto_vec[g])
            else $error("cleared override did not return to automatic value");

        chk_read_ov_bit: assert property ( // [RL1]
            rd_req && hit[g]
            |=> wb_dat_o[cpt_pkg::OVERRIDE_BIT] == $past(st_reg.ov[g]))
            else $error("read did not return override bit");

        chk_read_live_auto: assert property ( // [RL2]
            rd_req && hit[g] && !st_reg.ov[g]
            |=> wb_dat_o[cpt_pkg::VALUE_MSB:0] == $past(auto_vec[g]))
            else $error("read did not return automatic value");

        chk_read_override: assert property ( // [RL3]
            rd_req && hit[g] && st_reg.ov[g]
            |=> wb_dat_o[cpt_pkg::VALUE_MSB:0] == $past(st_reg.val[g]))
            else $error("read did not return stored value");
    end

    chk_port_lp_separate: assert property ( // [RL7]
        wr_hit[9] |=> $stable(st_reg.ov[0]) && $stable(st_reg.val[0]))
        else $error("port 1 low-power write touched port 0");

    chk_exit_before_lp: assert property ( // [RL6]
        wr_hit[8] ##0 $past(word_idx) == cpt_pkg::P1_DATA_EXIT_IDX |=> $stable(st_reg.ov[9]))
        else $error("data exit write touched low-power period");

    chk_p0_lp_alone: assert property ( // [RL7]
        wr_hit[0]
        |=> $stable(st_reg.ov[9]) && $stable(st_reg.val[9]))
        else $error("port 0 low-power write touched port 1");

    // Each named port carries its own slot
    chk_p0_lp_out: assert property ( // [RL7]
        p0_lp_period_value ==
        (override_en[0] ? st_reg.val[0] : p0_auto_lp_period))
        else $error("port 0 low-power timing source wrong");

    chk_clk_prepare_out: assert property ( // [RL5]
        p1_clk_prepare_value ==
        (override_en[1] ? st_reg.val[1] : p1_auto_clk_prepare))
        else $error("clock prepare timing source wrong");

    chk_clk_zero_out: assert property ( // [RL5]
        p1_clk_zero_value ==
        (override_en[2] ? st_reg.val[2] : p1_auto_clk_zero))
        else $error("clock zero timing source wrong");

    chk_clk_trail_out: assert property ( // [RL5]
        p1_clk_trail_value ==
        (override_en[3] ? st_reg.val[3] : p1_auto_clk_trail))
        else $error("clock trail timing source wrong");

    chk_clk_post_out: assert property ( // [RL5]
        p1_clk_post_value ==
        (override_en[4] ? st_reg.val[4] : p1_auto_clk_post))
        else $error("clock post timing source wrong");

    chk_data_prepare_out: assert property ( // [RL5]
        p1_data_prepare_value ==
        (override_en[5] ? st_reg.val[5] : p1_auto_data_prepare))
        else $error("data prepare timing source wrong");

    chk_data_zero_out: assert property ( // [RL5]
        p1_data_zero_value ==
        (override_en[6] ? st_reg.val[6] : p1_auto_data_zero))
        else $error("data zero timing source wrong");

    chk_data_trail_out: assert property ( // [RL5]
        p1_data_trail_value ==
        (override_en[7] ? st_reg.val[7] : p1_auto_data_trail))
        else $error("data trail timing source wrong");

    chk_data_exit_out: assert property ( // [RL5]
        p1_data_exit_value ==
        (override_en[8] ? st_reg.val[8] : p1_auto_data_exit))
        else $error("data exit timing source wrong");

    chk_p1_lp_out: assert property ( // [RL5]
        p1_lp_period_value ==
        (override_en[9] ? st_reg.val[9] : p1_auto_lp_period))
        else $error("port 1 low-power timing source wrong");

    cov_override_write: cover property (wr_hit[5] && wb_dat_i[cpt_pkg::OVERRIDE_BIT]);
    cov_read_auto:      cover property (rd_req && hit[0] && !st_reg.ov[0]);
    cov_read_override:  cover property (rd_req && hit[9] && st_reg.ov[9]);
    cov_unmapped_read:  cover property (rd_req && hit == '0);
    cov_sel_ignored:    cover property (req && wb_we_i && wb_ack_o && !wb_sel_i[0]);

endmodule : cpt_timing_override_regs

// [testbench.sv]
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                        mclk = 1'b0;
    logic                        reset_n = 1'b0;
    logic                        wb_cyc_i = 1'b0;
    logic                        wb_stb_i = 1'b0;
    logic                        wb_we_i = 1'b0;
    logic                        step = 1'b0;
    logic [cpt_pkg::ADR_W-1:0]   wb_adr_i = '0;
    logic [3:0]                  wb_sel_i = 4'h0;
    logic [31:0]                 wb_dat_i = 32'h0000_0000;
    logic [31:0]                 wb_dat_o;
    logic [31:0]                 rd;
    logic                        wb_ack_o;
    logic [9:0]                  override_en;
    logic [9:0][6:0]             auto_v;
    wire  [9:0][6:0]             use_v;
    int                          mismatches = 0;
    int                          cmp_count = 0;
    int                          ov[10];
    int                          val[10];
    always #2 mclk = ~mclk;
    cpt_auto_model i_cpt_auto_model (.mclk, .reset_n, .step, .auto_v);
    cpt_timing_override_regs i_cpt_timing_override_regs (
        .mclk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .p0_auto_lp_period(auto_v[0]), .p1_auto_clk_prepare(auto_v[1]), .p1_auto_clk_zero(auto_v[2]),
        .p1_auto_clk_trail(auto_v[3]), .p1_auto_clk_post(auto_v[4]), .p1_auto_data_prepare(auto_v[5]),
        .p1_auto_data_zero(auto_v[6]), .p1_auto_data_trail(auto_v[7]), .p1_auto_data_exit(auto_v[8]),
        .p1_auto_lp_period(auto_v[9]), .p0_lp_period_value(use_v[0]), .p1_clk_prepare_value(use_v[1]),
        .p1_clk_zero_value(use_v[2]), .p1_clk_trail_value(use_v[3]), .p1_clk_post_value(use_v[4]),
        .p1_data_prepare_value(use_v[5]), .p1_data_zero_value(use_v[6]), .p1_data_trail_value(use_v[7]),
        .p1_data_exit_value(use_v[8]), .p1_lp_period_value(use_v[9]), .override_en);
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h want %h", $time, msg, seen, exp);
        end
    endtask : chk
    function automatic int slot(input logic [6:0] idx);
        for (int i = 0; i < 10; i++) begin
            if (cpt_pkg::REG_IDX[i] == idx) begin
                return i;
            end
        end
        return -1;
    endfunction : slot
    function automatic logic [31:0] exp_rd(input logic [6:0] idx);
        int k;
        k = slot(idx);
        if (k < 0) begin
            return 32'h0000_0000;
        end
        return {24'h00_0000, ov[k] != 0, (ov[k] != 0) ? 7'(val[k]) : auto_v[k]};
    endfunction : exp_rd
    task automatic outs();
        for (int i = 0; i < 10; i++) begin
            chk(32'(use_v[i]), exp_rd(cpt_pkg::REG_IDX[i]) & 32'h0000_007f, "timing in use");
            chk(32'(override_en[i]), 32'(ov[i] != 0), "override bit");
        end
    endtask : outs
    task automatic wb(input logic we, input logic [6:0] idx, input logic [3:0] sel, input logic [31:0] d);
        int n;
        int k;
        n = 0;
        k = slot(idx);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_sel_i <= sel;
        wb_dat_i <= d;
        do begin
            @(posedge mclk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) begin
            mismatches++;
            $display("wrong value at %0t: no acknowledge", $time);
            end_of_test();
        end
        rd = wb_dat_o;
        if (we && sel[0] && k >= 0) begin
            ov[k] = d[7];
            val[k] = d[7] ? int'(d[6:0]) : val[k];
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge mclk);
    endtask : wb
    initial begin
        void'($urandom(32'h01a0));
        for (int i = 0; i < 10; i++) begin
            ov[i] = 0;
            val[i] = 0;
        end
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        for (int i = 0; i < 10; i++) begin
            wb(1'b0, cpt_pkg::REG_IDX[i], 4'hf, 32'h0000_0000);
            chk(rd, exp_rd(cpt_pkg::REG_IDX[i]), "reset read");
        end
        outs();
        $display("test reset values done");
        for (int i = 0; i < 10; i++) begin
            wb(1'b1, cpt_pkg::REG_IDX[i], 4'hf, $urandom & 32'hffff_ff7f);
            wb(1'b1, cpt_pkg::REG_IDX[i], 4'he, $urandom | 32'h0000_0080);
            wb(1'b0, cpt_pkg::REG_IDX[i], 4'hf, 32'h0000_0000);
            chk(rd, exp_rd(cpt_pkg::REG_IDX[i]), "value field locked");
        end
        $display("test locked value done");
        for (int i = 0; i < 10; i++) begin
            wb(1'b1, cpt_pkg::REG_IDX[i], 4'hf, $urandom | 32'h0000_0080);
            outs();
            wb(1'b0, cpt_pkg::REG_IDX[i], 4'hf, 32'h0000_0000);
            chk(rd, exp_rd(cpt_pkg::REG_IDX[i]), "override read back");
        end
        // Computed values move; overridden outputs must hold
        step <= 1'b1;
        @(posedge mclk);
        step <= 1'b0;
        repeat (2) @(posedge mclk);
        outs();
        $display("test override done");
        wb(1'b1, cpt_pkg::P0_LP_PERIOD_IDX, 4'hf, 32'h0000_0000);
        outs();
        wb(1'b0, cpt_pkg::P1_LP_PERIOD_IDX, 4'hf, 32'h0000_0000);
        chk(rd, exp_rd(cpt_pkg::P1_LP_PERIOD_IDX), "port 1 lp kept");
        $display("test port independence done");
        for (int a = 7'h49; a < 7'h6a; a += 8'h10) begin
            wb(1'b1, 7'(a), 4'hf, 32'h0000_00ff);
            wb(1'b0, 7'(a), 4'hf, 32'h0000_0000);
            chk(rd, 32'h0000_0000, "unmapped word");
        end
        outs();
        $display("test unmapped done");
        reset_n <= 1'b0;
        @(posedge mclk);
        reset_n <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            ov[i] = 0;
            val[i] = 0;
        end
        @(posedge mclk);
        outs();
        $display("test second reset done");
        end_of_test();
    end
endmodule : testbench
